// ### hw/epm_pkg.sv
// Constants, field layouts and carrier types for the external PM inputs
package epm_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_HZ           = 50_000_000; // System clock rate
  localparam int DEBOUNCE_MS      = 5;          // Least stable time
  // Least time, rounded up to whole cycles
  localparam int DEBOUNCE_CYCLES  = (DEBOUNCE_MS * CLK_HZ + 999) / 1000;
  localparam int ANY_EDGE_HOLD_MS = 20;         // Source hold, any-edge mode

  // ********************************************************************
  // Structure
  // ********************************************************************
  localparam int NUM_INPUTS = 2;  // Inputs b and c
  localparam int ADDR_W     = 12; // AXI byte address width

  // ********************************************************************
  // Register indices; byte address is four times the index
  // ********************************************************************
  localparam logic [7:0] IDX_CTRL_B     = 8'hFD;
  localparam logic [7:0] IDX_CTRL_C     = 8'hFE;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hE0;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'hE1;

  // ********************************************************************
  // Reset values and field positions
  // ********************************************************************
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam int         STAT_W          = 4;
  localparam int         STAT_EVENT_LSB  = 0; // One event bit per input
  localparam int         STAT_RELOAD_LSB = 2; // One reload bit per input
  localparam logic [3:0] STAT_RESET      = 4'h0;
  localparam logic [3:0] MASK_RESET      = 4'h0;

  // ********************************************************************
  // AXI responses
  // ********************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************************************************************
  // Types
  // ********************************************************************
  // Per-input control register layout, bit 7 first
  typedef struct packed {
    logic       event_en;    // Activity raises a power-saving event
    logic       reload_en;   // Activity reloads the wake-up timer unless event_en is set
    logic       pol_any;     // Any transition triggers
    logic       pol_rise;    // Rising edge when pol_any is clear
    logic       debounce_en; // Filter glitches
    logic [2:0] rsvd;        // Stored, software writes zero
  } epm_ctrl_t;

  // Per-input trigger outputs
  typedef struct packed {
    logic event_hit;  // Power-saving event pulse
    logic reload_hit; // Timer reload pulse
  } epm_hit_t;

endpackage

// ### hw/epm_event_inputs.sv
// External power-management input pins with AXI4-Lite control registers
// Functional notes
// - Bit 7 set: activity raises power-saving event
// - Read bit 7 shows event caused here
// - Bit 6 set: activity reloads wake-up timer (here only while bit 7 is clear)
// - Polarity 00 triggers on falling edge
// - Polarity 01 triggers on rising edge
// - Polarity 1X triggers on any transition
// - Bit 3 set applies debounce filter
// - Second input has own identical register
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module epm_event_inputs
  import epm_pkg::*;
#(
  parameter int DEB_CYCLES = epm_pkg::DEBOUNCE_CYCLES // Debounce length
) (
  // Clock, reset and enable
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      ce,
  // Write address channel
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [epm_pkg::ADDR_W-1:0] s_axi_awaddr,
  // Write data channel
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  // Write response channel
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output var  logic [1:0]                s_axi_bresp,
  // Read address channel
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  input  wire logic [epm_pkg::ADDR_W-1:0] s_axi_araddr,
  // Read data channel
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  // External pins, active low
  input  wire logic                      ext_pm_input_b_n,
  input  wire logic                      ext_pm_input_c_n,
  // Power-management outputs
  output var  logic [1:0]                power_saving_event,
  output var  logic [1:0]                timer_reload,
  output var  logic                      irq
);
  import epm_pkg::*;

  // ********************************************************************
  // Declarations
  // ********************************************************************
  localparam int CNT_W = $clog2(DEB_CYCLES + 1); // Debounce counter width
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEB_CYCLES - 1);

  epm_ctrl_t                 ctrl [NUM_INPUTS];   // Control registers
  logic [NUM_INPUTS-1:0]     cause;               // Event-caused flags
  logic [STAT_W-1:0]         irq_status;          // Sticky events
  logic [STAT_W-1:0]         irq_mask;            // Interrupt enables
  epm_hit_t [NUM_INPUTS-1:0] hit;                 // Per-input triggers
  logic [NUM_INPUTS-1:0]     pin_raw;             // Pins as sampled

  logic                      aw_held;             // Write address latched
  logic                      w_held;              // Write data latched
  logic [7:0]                aw_idx;              // Latched write index
  logic [7:0]                w_byte;              // Latched write byte
  logic                      w_lane0;             // Low byte lane enabled
  logic                      wr_fire;             // Write performed now
  logic                      rd_fire;             // Read accepted now
  logic [7:0]                ar_idx;              // Index of the read
  logic [NUM_INPUTS-1:0]     ctrl_wr;             // Control reg written
  logic                      stat_rd;             // Status read-clear
  logic [31:0]               next_rdata;          // Read mux result
  logic                      next_rd_ok;          // Read hits a register
  logic                      next_wr_ok;          // Write hits a register

  assign pin_raw = {ext_pm_input_c_n, ext_pm_input_b_n};

  // ********************************************************************
  // Per-input synchroniser, debounce and edge qualification
  // ********************************************************************
  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
    logic             sync_a;  // First synchroniser stage
    logic             sync_b;  // Second synchroniser stage
    logic             filt;    // Debounced level
    logic [CNT_W-1:0] cnt;     // Stability counter
    logic             prev;    // Level seen last cycle
    logic             lvl;     // Level under qualification
    logic             fall;    // Falling edge
    logic             rise;    // Rising edge
    logic             trig;    // Qualified activity

    // Two flops; only sync_b is looked at by the logic below
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync_a <= 1'b1;
        sync_b <= 1'b1;
      end else if (ce) begin
        sync_a <= pin_raw[i];
        sync_b <= sync_a;
      end
    end

    // Filter follows the pin only after DEB_CYCLES of a steady new level.
    // With the filter off it tracks directly so enabling it adds no edge.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        filt <= 1'b1;
        cnt  <= '0;
      end else if (ce) begin
        if (!ctrl[i].debounce_en || sync_b == filt) begin
          filt <= sync_b;
          cnt  <= '0;
        end else if (cnt == CNT_LAST) begin
          filt <= sync_b;
          cnt  <= '0;
        end else begin
          cnt <= cnt + CNT_W'(1);
        end
      end
    end

    // Choose raw or filtered level
    assign lvl  = ctrl[i].debounce_en ? filt : sync_b;
    assign fall = prev & ~lvl;
    assign rise = ~prev & lvl;

    // Edge selection; any-edge mode ignores the rise bit
    always_comb begin
      if (ctrl[i].pol_any) begin
        trig = fall | rise;
      end else if (ctrl[i].pol_rise) begin
        trig = rise;
      end else begin
        trig = fall;
      end
    end

    // Previous level for edge detection
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        prev <= 1'b1;
      end else if (ce) begin
        prev <= lvl;
      end
    end

    // Event wins if both bits are set; software must not do that
    assign hit[i].event_hit  = trig & ctrl[i].event_en;
    assign hit[i].reload_hit = trig & ctrl[i].reload_en
                               & ~ctrl[i].event_en;
  end

  // ********************************************************************
  // Trigger outputs, registered one-cycle pulses
  // ********************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_saving_event <= '0;
      timer_reload       <= '0;
    end else if (ce) begin
      for (int k = 0; k < NUM_INPUTS; k++) begin
        power_saving_event[k] <= hit[k].event_hit;
        timer_reload[k]       <= hit[k].reload_hit;
      end
    end
  end

  // ********************************************************************
  // AXI write path
  // ********************************************************************
  // Address and data may come in either order; each is held until both
  // are here, then one write happens and the response is raised.
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_idx        <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[9:2];
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      // Ready one cycle after valid while no address is held
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_held;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_byte       <= 8'h00;
      w_lane0      <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
      s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_held;
    end
  end

  // Address decode of the held write
  always_comb begin
    next_wr_ok = 1'b0;
    ctrl_wr    = '0;
    case (aw_idx)
      IDX_CTRL_B: begin
        next_wr_ok = 1'b1;
        ctrl_wr[0] = wr_fire && w_lane0;
      end
      IDX_CTRL_C: begin
        next_wr_ok = 1'b1;
        ctrl_wr[1] = wr_fire && w_lane0;
      end
      IDX_IRQ_STATUS: begin
        next_wr_ok = 1'b1; // Read-only, write ignored
      end
      IDX_IRQ_MASK: begin
        next_wr_ok = 1'b1;
      end
      default: begin
        next_wr_ok = 1'b0; // Unmapped, answered with SLVERR
      end
    endcase
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= next_wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  // Control registers; reserved bits are stored as written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < NUM_INPUTS; k++) begin
        ctrl[k] <= epm_ctrl_t'(CTRL_RESET);
      end
    end else if (ce) begin
      for (int k = 0; k < NUM_INPUTS; k++) begin
        if (ctrl_wr[k]) begin
          ctrl[k] <= epm_ctrl_t'(w_byte);
        end
      end
    end
  end

  // Cause flags: set on an event, cleared by a write of the register.
  // A new event in the same cycle as the write still sets the flag.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause <= '0;
    end else if (ce) begin
      for (int k = 0; k < NUM_INPUTS; k++) begin
        if (hit[k].event_hit) begin
          cause[k] <= 1'b1;
        end else if (ctrl_wr[k]) begin
          cause[k] <= 1'b0;
        end
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= MASK_RESET;
    end else if (ce && wr_fire && w_lane0 && aw_idx == IDX_IRQ_MASK) begin
      irq_mask <= w_byte[STAT_W-1:0];
    end
  end

  // Sticky status; a read clears it, but a set in that cycle wins
  assign stat_rd = rd_fire && ar_idx == IDX_IRQ_STATUS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= STAT_RESET;
    end else if (ce) begin
      for (int k = 0; k < NUM_INPUTS; k++) begin
        if (hit[k].event_hit) begin
          irq_status[STAT_EVENT_LSB + k] <= 1'b1;
        end else if (stat_rd) begin
          irq_status[STAT_EVENT_LSB + k] <= 1'b0;
        end
        if (hit[k].reload_hit) begin
          irq_status[STAT_RELOAD_LSB + k] <= 1'b1;
        end else if (stat_rd) begin
          irq_status[STAT_RELOAD_LSB + k] <= 1'b0;
        end
      end
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ********************************************************************
  // AXI read path
  // ********************************************************************
  // Address is taken only while no read data is pending
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign ar_idx  = s_axi_araddr[9:2];

  // Read mux; bit 7 of a control register reports the cause flag
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rd_ok = 1'b1;
    case (ar_idx)
      IDX_CTRL_B: begin
        next_rdata[7:0] = {cause[0], ctrl[0][6:0]};
      end
      IDX_CTRL_C: begin
        next_rdata[7:0] = {cause[1], ctrl[1][6:0]};
      end
      IDX_IRQ_STATUS: begin
        next_rdata[STAT_W-1:0] = irq_status;
      end
      IDX_IRQ_MASK: begin
        next_rdata[STAT_W-1:0] = irq_mask;
      end
      default: begin
        next_rd_ok = 1'b0;
      end
    endcase
  end

  // Read address ready and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ### dv/epm_event_inputs_chk.sv
// Port-level checker for the external PM input block
`timescale 1ns/1ns
`default_nettype none

module epm_event_inputs_chk #(
  parameter int DEB_CYCLES = 8 // Debounce length, unused by the checks
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Power-management outputs
  input wire logic [1:0]  power_saving_event,
  input wire logic [1:0]  timer_reload,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held more than one cycle");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid)
    else $error("bvalid stayed after handshake");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read data late");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid)
    else $error("rvalid stayed after handshake");
  rd_upper_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // Pins must hold a level for long periods, so pulses never abut
  ev_pulse_a: assert property (
    (power_saving_event & $past(power_saving_event)) == 2'h0)
    else $error("event pulse wider than one cycle");
  excl_a: assert property ((power_saving_event & timer_reload) == 2'h0)
    else $error("event and reload together");
  irq_rise_a: assert property ($rose(irq) |->
    |($past(power_saving_event) | $past(timer_reload)) ||
    $past(s_axi_bvalid))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |->
    $past(s_axi_rvalid) || $past(s_axi_bvalid))
    else $error("irq fell without status read or mask write");
endmodule

bind epm_event_inputs epm_event_inputs_chk #(.DEB_CYCLES(DEB_CYCLES))
  i_epm_event_inputs_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .power_saving_event(power_saving_event),
  .timer_reload(timer_reload), .irq(irq));

`default_nettype wire

// ### dv/epm_pin_src.sv
// Model of the two external wake sources that drive the pins
`timescale 1ns/1ns
`default_nettype none

module epm_pin_src (
  // Clock
  input  wire logic aclk,
  // Pins, idle high through pull-ups
  output var  logic pin_b_n,
  output var  logic pin_c_n
);
  // Pull-ups hold both pins high until a source acts
  initial begin
    pin_b_n = 1'b1;
    pin_c_n = 1'b1;
  end

  // Move one pin just after an edge, then keep it for hold cycles
  task automatic drive(input int idx, input logic lvl, input int hold);
    if (idx == 0) begin
      pin_b_n <= lvl;
    end else begin
      pin_c_n <= lvl;
    end
    repeat (hold) @(posedge aclk);
  endtask
endmodule

`default_nettype wire

// ### dv/epm_event_inputs_tb.sv
// Self-checking bench for the external PM input block
`timescale 1ns/1ns
`default_nettype none

module epm_event_inputs_tb;
  import epm_pkg::*;
  // ********************************************************************
  // Wiring
  // ********************************************************************
  localparam int          DEB  = 8;       // Shortened debounce
  localparam int          HOLD = DEB + 8; // Covers sync plus filter
  localparam logic [11:0] A_B  = {2'h0, IDX_CTRL_B, 2'h0};
  localparam logic [11:0] A_C  = {2'h0, IDX_CTRL_C, 2'h0};
  localparam logic [11:0] A_S  = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] A_M  = {2'h0, IDX_IRQ_MASK, 2'h0};
  localparam logic [7:0]  MODES [8] = '{8'h80, 8'h90, 8'hA0, 8'hB0,
                                        8'h40, 8'h50, 8'h00, 8'h98};
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, irq, pb_n, pc_n;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, ev, rl;
  logic [3:0]  strb;
  int          num_errors, samples_checked, cycles;
  int          ev_cnt [2];
  int          rl_cnt [2];

  epm_event_inputs #(.DEB_CYCLES(DEB)) i_epm_event_inputs (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .ext_pm_input_b_n(pb_n), .ext_pm_input_c_n(pc_n),
    .power_saving_event(ev), .timer_reload(rl), .irq(irq));
  epm_pin_src i_epm_pin_src (.aclk(aclk), .pin_b_n(pb_n), .pin_c_n(pc_n));

  // Pulse counters; non-blocking so tasks read a settled value
  always @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      ev_cnt[i] <= ev_cnt[i] + int'(ev[i]);
      rl_cnt[i] <= rl_cnt[i] + int'(rl[i]);
    end
  end
  // Watchdog: the whole run needs a little over a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ********************************************************************
  // Bus and compare tasks
  // ********************************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
  task automatic wrc(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic rdc(input string what, input logic [11:0] a,
                     input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
    chk(what, d, exp);
  endtask
  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic s_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rdc("ctrl_b reset", A_B, 32'h0);
    rdc("ctrl_c reset", A_C, 32'h0);
    rdc("mask reset", A_M, 32'h0);
    axr(12'h004, d, r);
    chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    chk("unmapped rdata", d, 32'h0);
    axw(12'h004, 32'hFF, r);
    chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    wrc(A_C, 32'hFFFF_FF58);
    rdc("ctrl_c fields", A_C, 32'h58);
    strb <= 4'h0;
    wrc(A_C, 32'h0000_0080);
    strb <= 4'hF;
    rdc("ctrl_c lane off", A_C, 32'h58);
    wrc(A_S, 32'h0000_000F);
    rdc("status read only", A_S, 32'h0);
  endtask
  // Fall then rise on one pin; expectations follow the control bits
  task automatic s_trig(input int idx, input logic [7:0] c);
    int          e0, r0, n;
    logic [11:0] a;
    logic [31:0] d;
    logic [1:0]  r;
    a = (idx == 0) ? A_B : A_C;
    n = int'(c[5] || !c[4]) + int'(c[5] || c[4]);
    wrc(a, {24'h0, c});
    repeat (HOLD) @(posedge aclk);
    axr(A_S, d, r);
    e0 = ev_cnt[idx];
    r0 = rl_cnt[idx];
    i_epm_pin_src.drive(idx, 1'b0, HOLD);
    i_epm_pin_src.drive(idx, 1'b1, HOLD);
    chk("events", ev_cnt[idx] - e0, c[7] ? n : 0);
    chk("reloads", rl_cnt[idx] - r0, c[6] ? n : 0);
    rdc("cause", a, {24'h0, c[7] && n > 0, c[6:0]});
    rdc("status", A_S, (c[7] ? 32'h1 : c[6] ? 32'h4 : 32'h0) << idx);
  endtask
  // A three-cycle glitch is filtered only with debounce on
  task automatic s_deb();
    int e0;
    for (int k = 0; k < 2; k++) begin
      wrc(A_B, (k == 0) ? 32'h88 : 32'h80);
      repeat (HOLD) @(posedge aclk);
      e0 = ev_cnt[0];
      i_epm_pin_src.drive(0, 1'b0, 3);
      i_epm_pin_src.drive(0, 1'b1, HOLD);
      chk("glitch events", ev_cnt[0] - e0, k);
    end
  endtask
  task automatic s_irq();
    logic [31:0] d;
    logic [1:0]  r;
    wrc(A_M, 32'h1);
    rdc("mask", A_M, 32'h1);
    wrc(A_C, 32'h80);
    repeat (HOLD) @(posedge aclk);
    axr(A_S, d, r);
    i_epm_pin_src.drive(0, 1'b0, HOLD);
    chk("irq set", {31'h0, irq}, 32'h1);
    rdc("status b", A_S, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    i_epm_pin_src.drive(1, 1'b0, HOLD);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rdc("status c", A_S, 32'h2);
    i_epm_pin_src.drive(0, 1'b1, HOLD);
    i_epm_pin_src.drive(1, 1'b1, HOLD);
  endtask
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 56'h0;
    strb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_regs();
    for (int i = 0; i < 2; i++) begin
      for (int m = 0; m < 8; m++) s_trig(i, MODES[m]);
    end
    s_deb();
    s_irq();
    report_and_stop();
  end
endmodule

`default_nettype wire
